// ---- axs_seq.sv ----
// Asynchronous enclave exit sequencer with its APB register file.
// Assumes one event at a time from the delivery logic on pclk.
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// (RULE1) In 32-bit mode save only low halves of legacy GPRs, IP, flags.
// (RULE2) In 64-bit long mode save all 64-bit GPRs, extended ones included.
// (RULE3) Save enabled extended features; first 512 bytes use mode layout.
// (RULE4) Record the exit reason in the frame's exit information.
// (RULE5) Save each misc feature chosen by the misc select mask.
// (RULE6) Load synthetic registers; reset masked features of bits 62:2.
// (RULE7) Breakpoints suppressed on entry become active again on exit.
// (RULE8) Frame trap flag saved as 0; live one restored unless opted in.
// (RULE9) Clear live resume flag; frame keeps it for traps, 1 for faults.
// (RULE10) Repeat-prefixed intermediate iteration saves resume flag as 1.
// (RULE11) Resume suppressed monitoring, sampling, branch records, trace; here perf_resume only without opt-in.
// (RULE12) Save FS/GS bases, then restore FS/GS from entry copies.
// (RULE13) Zero header bytes 8 to 23; mask header bitmap with feature mask.
// (RULE14) Reload stack and frame pointers from the frame's GPR area.
// (RULE15) Listed exceptions: vector, kind 6 for breakpoint else 3, valid.
// (RULE16) PF/GP with misc bit 0: vector, kind 3, valid, fault details.
// (RULE17) Load IP and counter with exit pointer, accumulator 3, base TLA.
// (RULE18) Increment the current save frame index by one on every exit.
// (RULE19) Restore XCR0 if enabled, leave enclave mode, flush translations.
// (RULE20) Without opt-in restore breakpoints, trap flag, monitor trap, perf.
// (RULE21) Pend a monitor-trap VM exit when the control is set.
// (RULE22) On page fault clear the low 12 fault address bits last.
module axs_seq (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              evt_req,
  input  wire axs_pkg::axs_evt_t evt,
  input  wire logic [31:0]       hdr_bv_in,
  input  wire logic [31:0]       fault_addr_in,
  input  wire logic [31:0]       err_code_in,
  output logic                   busy,
  output logic                   gpr_save,
  output logic                   save_wide64,
  output logic                   fx_fmt64,
  output logic [31:0]            xsave_en_mask,
  output logic [7:0]             misc_save_mask,
  output logic                   fsgs_base_save,
  output logic                   ssa_tf,
  output logic                   ssa_rf,
  output logic                   hdr_clear,
  output logic [31:0]            hdr_bv_out,
  output logic                   info_wr,
  output logic                   misc_wr,
  output axs_pkg::axs_misc_t     misc_out,
  output logic                   synth_load,
  output axs_pkg::axs_syn_t      syn,
  output logic [31:0]            xinit_mask,
  output logic                   stack_reload,
  output logic                   fsgs_restore,
  output logic                   live_rf_clear,
  output logic                   xcr0_restore,
  output logic                   tlb_flush,
  output logic                   bp_outside_resume,
  output logic                   dbg_restore,
  output logic                   live_tf,
  output logic                   perf_resume,
  output logic                   mon_trap_pend,
  output logic                   cr2_low_clear,
  output logic                   done
);

  ////////////////////////////////////////////////////////////////////
  // Register file
  logic [31:0]      ctrl_r;
  logic [31:0]      feat_r;
  logic [31:0]      eptr_r;
  logic [31:0]      tla_r;
  logic [31:0]      fidx_r;
  logic [31:0]      xinfo_r;
  logic [31:0]      xinfo_nxt;
  axs_pkg::axs_st_t st_r;
  axs_pkg::axs_st_t st_nxt;
  axs_pkg::axs_evt_t ev_r;

  // APB decode, zero-wait with registered answer
  wire setup   = psel & ~penable;
  wire wr_go   = psel & penable & pready & pwrite;
  wire hit_c   = paddr == axs_pkg::OFS_CTRL;
  wire hit_f   = paddr == axs_pkg::OFS_FEAT;
  wire hit_e   = paddr == axs_pkg::OFS_EPTR;
  wire hit_t   = paddr == axs_pkg::OFS_TLA;
  wire hit_i   = paddr == axs_pkg::OFS_FIDX;
  wire hit_x   = paddr == axs_pkg::OFS_XINFO;
  wire hit_s   = paddr == axs_pkg::OFS_STAT;
  wire hit_h   = paddr == axs_pkg::OFS_XHDR;
  wire mapped  = hit_c | hit_f | hit_e | hit_t | hit_i | hit_x | hit_s | hit_h;
  wire wr_ctrl = wr_go & hit_c;
  wire [31:0] stat_w = {28'h0000000, st_r, busy};
  wire [31:0] rd_mux =
    hit_c ? ctrl_r :
    hit_f ? feat_r :
    hit_e ? eptr_r :
    hit_t ? tla_r  :
    hit_i ? fidx_r :
    hit_x ? xinfo_r :
    hit_s ? stat_w :
    hit_h ? hdr_bv_out : 32'h0000_0000;

  // Answer is latched in setup, so access always sees pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Event classification
  wire go = (st_r == axs_pkg::ST_IDLE) & evt_req;
  axs_pkg::axs_evt_t ev_s;
  assign ev_s = go ? evt : ev_r;
  wire [7:0] vec    = ev_s.vector;
  wire mode64       = ev_s.efer_lma & ev_s.cs_l;
  wire is_brk       = vec == axs_pkg::VEC_BRK;
  wire is_pf        = vec == axs_pkg::VEC_PF;
  wire is_gp        = vec == axs_pkg::VEC_GP;
  wire is_list      = (vec == axs_pkg::VEC_DIV) | (vec == axs_pkg::VEC_DBG) |
                      is_brk | (vec == axs_pkg::VEC_BND) |
                      (vec == axs_pkg::VEC_UD) | (vec == axs_pkg::VEC_MATH) |
                      (vec == axs_pkg::VEC_ALIGN) | (vec == axs_pkg::VEC_SIMD);
  wire misc0        = ctrl_r[axs_pkg::CTRL_MISC];
  wire fault_rec    = (is_pf | is_gp) & misc0;
  wire optin        = ctrl_r[axs_pkg::CTRL_OPTIN];
  // (RULE9) Faults force resume flag to 1
  // (RULE10) Repeat iteration forces it too
  wire rf_save      = ev_s.rep_mid | ~ev_s.keep_rf | ev_s.arch_rf;

  localparam int XI_VEC_HI  = axs_pkg::XI_VEC + 7;
  localparam int XI_KIND_HI = axs_pkg::XI_KIND + 2;

  // Exit information word
  always_comb begin
    xinfo_nxt = 32'h0000_0000;
    // (RULE15) Listed exception codes
    if (is_list) begin
      xinfo_nxt[XI_VEC_HI:axs_pkg::XI_VEC] = vec;
      xinfo_nxt[XI_KIND_HI:axs_pkg::XI_KIND] =
        is_brk ? axs_pkg::KIND_BRK : axs_pkg::KIND_EXC;
      xinfo_nxt[axs_pkg::XI_VAL] = 1'b1;
    // (RULE16) Reported PF/GP, else all zero
    end else if (fault_rec) begin
      xinfo_nxt[XI_VEC_HI:axs_pkg::XI_VEC] = vec;
      xinfo_nxt[XI_KIND_HI:axs_pkg::XI_KIND] = axs_pkg::KIND_EXC;
      xinfo_nxt[axs_pkg::XI_VAL] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sequencer; events arriving while busy are not taken
  always_comb begin
    unique case (st_r)
      axs_pkg::ST_IDLE:  st_nxt = evt_req ? axs_pkg::ST_SAVE : axs_pkg::ST_IDLE;
      axs_pkg::ST_SAVE:  st_nxt = axs_pkg::ST_XHDR;
      axs_pkg::ST_XHDR:  st_nxt = axs_pkg::ST_INFO;
      axs_pkg::ST_INFO:  st_nxt = axs_pkg::ST_SYNTH;
      axs_pkg::ST_SYNTH: st_nxt = axs_pkg::ST_FRAME;
      axs_pkg::ST_FRAME: st_nxt = axs_pkg::ST_EXIT;
      axs_pkg::ST_EXIT:  st_nxt = axs_pkg::ST_TAIL;
      axs_pkg::ST_TAIL:  st_nxt = axs_pkg::ST_IDLE;
    endcase
  end
  wire n_save  = st_nxt == axs_pkg::ST_SAVE;
  wire n_xhdr  = st_nxt == axs_pkg::ST_XHDR;
  wire n_info  = st_nxt == axs_pkg::ST_INFO;
  wire n_synth = st_nxt == axs_pkg::ST_SYNTH;
  wire n_frame = st_nxt == axs_pkg::ST_FRAME;
  wire n_exit  = st_nxt == axs_pkg::ST_EXIT;
  wire n_tail  = st_nxt == axs_pkg::ST_TAIL;

  // State and captured event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= axs_pkg::ST_IDLE;
      ev_r <= '0;
      busy <= 1'b0;
    end else begin
      st_r <= st_nxt;
      ev_r <= ev_s;
      busy <= st_nxt != axs_pkg::ST_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Software registers; hardware index step and exit win over writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= axs_pkg::CTRL_RST;
      feat_r <= 32'h0000_0000;
      eptr_r <= 32'h0000_0000;
      tla_r  <= 32'h0000_0000;
      fidx_r <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= pwdata & axs_pkg::CTRL_MSK;
      end
      // (RULE19) Leave enclave mode, later so it beats a write
      if (n_exit) begin
        ctrl_r[axs_pkg::CTRL_EMODE] <= 1'b0;
      end
      if (wr_go & hit_f) begin
        feat_r <= pwdata;
      end
      if (wr_go & hit_e) begin
        eptr_r <= pwdata;
      end
      if (wr_go & hit_t) begin
        tla_r <= pwdata;
      end
      // (RULE18) Step frame index
      if (n_frame) begin
        fidx_r <= fidx_r + 32'h0000_0001;
      end else if (wr_go & hit_i) begin
        fidx_r <= pwdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Save phase outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpr_save       <= 1'b0;
      save_wide64    <= 1'b0;
      fx_fmt64       <= 1'b0;
      xsave_en_mask  <= 32'h0000_0000;
      misc_save_mask <= 8'h00;
      fsgs_base_save <= 1'b0;
      ssa_tf         <= 1'b0;
      ssa_rf         <= 1'b0;
    end else begin
      gpr_save       <= n_save;
      // (RULE1) Narrow save outside 64-bit mode
      // (RULE2) Full width in long mode
      save_wide64    <= n_save & mode64;
      // (RULE3) Feature mask and layout
      fx_fmt64       <= n_save & mode64;
      xsave_en_mask  <= n_save ? feat_r : 32'h0000_0000;
      // (RULE5) Misc features to save
      misc_save_mask <= n_save ? ctrl_r[axs_pkg::CTRL_MISC +: axs_pkg::MISC_W] : 8'h00;
      // (RULE12) Bases go to the frame first
      fsgs_base_save <= n_save;
      // (RULE8) Frame trap flag is zero
      ssa_tf         <= 1'b0;
      ssa_rf         <= n_save & rf_save;
    end
  end

  // Header fix-up and exit information
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hdr_clear  <= 1'b0;
      hdr_bv_out <= 32'h0000_0000;
      info_wr    <= 1'b0;
      misc_wr    <= 1'b0;
      misc_out   <= '0;
      xinfo_r    <= 32'h0000_0000;
    end else begin
      // (RULE13) Clear bytes 8-23, mask bitmap
      hdr_clear <= n_xhdr;
      if (n_xhdr) begin
        hdr_bv_out <= hdr_bv_in & feat_r;
      end
      // (RULE4) Reason into exit information
      info_wr <= n_info;
      if (n_info) begin
        xinfo_r <= xinfo_nxt;
      end
      // (RULE16) Fault address or zero, code, reserved zero
      misc_wr <= n_info & fault_rec;
      if (n_info & fault_rec) begin
        misc_out.fault_addr <= is_pf ? fault_addr_in : 32'h0000_0000;
        misc_out.err_code   <= err_code_in;
        misc_out.rsvd       <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Synthetic state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      synth_load    <= 1'b0;
      syn           <= '0;
      xinit_mask    <= 32'h0000_0000;
      stack_reload  <= 1'b0;
      fsgs_restore  <= 1'b0;
      live_rf_clear <= 1'b0;
    end else begin
      // (RULE6) Synthetic load with init mask
      synth_load <= n_synth;
      xinit_mask <= n_synth ? (feat_r & axs_pkg::XINIT_MSK) : 32'h0000_0000;
      // (RULE17) Resume register setup
      if (n_synth) begin
        syn.rip <= eptr_r;
        syn.rax <= axs_pkg::RESUME_LEAF;
        syn.rbx <= tla_r;
        syn.rcx <= eptr_r;
      end
      // (RULE14) Untrusted stack pointers back
      stack_reload  <= n_synth;
      // (RULE12) Selectors from entry copies
      fsgs_restore  <= n_synth;
      // (RULE9) Live resume flag cleared
      live_rf_clear <= n_synth;
    end
  end

  // Leaving the enclave
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xcr0_restore      <= 1'b0;
      tlb_flush         <= 1'b0;
      bp_outside_resume <= 1'b0;
      dbg_restore       <= 1'b0;
      live_tf           <= 1'b0;
      perf_resume       <= 1'b0;
      mon_trap_pend     <= 1'b0;
      cr2_low_clear     <= 1'b0;
      done              <= 1'b0;
    end else begin
      // (RULE19) XCR0 only when enabled
      xcr0_restore      <= n_frame & ev_s.osxsave;
      tlb_flush         <= n_exit;
      // (RULE7) Outside-range breakpoints back
      bp_outside_resume <= n_exit;
      // (RULE20) Debug restore without opt-in
      dbg_restore       <= n_exit & ~optin;
      // (RULE8) Trap flag from entry copy
      if (n_exit & ~optin) begin
        live_tf <= ctrl_r[axs_pkg::CTRL_STF];
      end
      // (RULE11) Monitoring resumes, counters promoted
      perf_resume       <= n_exit & ~optin;
      // (RULE21) Monitor trap pends at the end
      mon_trap_pend     <= n_tail & ev_s.vmx_mon_trap;
      // (RULE22) Page fault address clean-up last
      cr2_low_clear     <= n_tail & is_pf;
      done              <= n_tail;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_narrow;
    gpr_save && !(ev_r.efer_lma && ev_r.cs_l) |-> !save_wide64 && !fx_fmt64;
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow save wrong"); // (RULE1)

  property p_wide;
    gpr_save && ev_r.efer_lma && ev_r.cs_l |-> save_wide64 && fx_fmt64;
  endproperty
  a_wide: assert property (p_wide) else $error("wide save wrong"); // (RULE2)

  property p_feat;
    gpr_save |-> xsave_en_mask == feat_r && fx_fmt64 == save_wide64;
  endproperty
  a_feat: assert property (p_feat) else $error("feature save mask wrong"); // (RULE3)

  property p_rfault;
    gpr_save && !ev_r.keep_rf |-> ssa_rf && !ssa_tf;
  endproperty
  a_rfault: assert property (p_rfault) else $error("fault resume flag"); // (RULE9)

  property p_rep;
    gpr_save && ev_r.rep_mid |-> ssa_rf;
  endproperty
  a_rep: assert property (p_rep) else $error("repeat resume flag"); // (RULE10)

  property p_brk;
    info_wr && ev_r.vector == axs_pkg::VEC_BRK |->
      xinfo_r[10:8] == 3'h6 && xinfo_r[31] && xinfo_r[7:0] == 8'h03;
  endproperty
  a_brk: assert property (p_brk) else $error("breakpoint exit info"); // (RULE15)

  property p_nolog;
    info_wr && ev_r.vector == axs_pkg::VEC_PF && !misc0 |-> xinfo_r == 32'h0 && !misc_wr;
  endproperty
  a_nolog: assert property (p_nolog) else $error("unreported fault logged"); // (RULE16)

  property p_leaf;
    synth_load |-> syn.rax == axs_pkg::RESUME_LEAF && syn.rip == eptr_r &&
      syn.rcx == eptr_r && syn.rbx == tla_r && stack_reload;
  endproperty
  a_leaf: assert property (p_leaf) else $error("resume registers wrong"); // (RULE17)

  property p_fidx;
    gpr_save |-> ##4 fidx_r == $past(fidx_r, 4) + 32'h1;
  endproperty
  a_fidx: assert property (p_fidx) else $error("frame index not stepped"); // (RULE18)

  property p_seq;
    $rose(gpr_save) |-> ##1 hdr_clear ##1 info_wr ##1 synth_load ##2 tlb_flush ##1 done;
  endproperty
  a_seq: assert property (p_seq) else $error("exit order wrong"); // (RULE19)

  property p_mtf;
    gpr_save && ev_r.vmx_mon_trap |-> ##6 mon_trap_pend && done;
  endproperty
  a_mtf: assert property (p_mtf) else $error("monitor trap not pended"); // (RULE21)

  property p_cr2;
    cr2_low_clear |-> done && ev_r.vector == axs_pkg::VEC_PF;
  endproperty
  a_cr2: assert property (p_cr2) else $error("fault address clear misplaced"); // (RULE22)

  c_brk:   cover property (info_wr && xinfo_r[10:8] == 3'h6);
  c_pf:    cover property (misc_wr && ev_r.vector == axs_pkg::VEC_PF);
  c_rep:   cover property (gpr_save && ev_r.rep_mid);
  c_optin: cover property (tlb_flush && !dbg_restore);

endmodule // axs_seq
`default_nettype wire

// ---- axs_pkg.sv ----
// Constants, register map and carrier types of the exit sequencer.
// Assumes a 32-bit APB register bus and a core that hands over one event.
package axs_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_FEAT  = 8'h04;
  localparam logic [7:0] OFS_EPTR  = 8'h08;
  localparam logic [7:0] OFS_TLA   = 8'h0C;
  localparam logic [7:0] OFS_FIDX  = 8'h10;
  localparam logic [7:0] OFS_XINFO = 8'h14;
  localparam logic [7:0] OFS_STAT  = 8'h18;
  localparam logic [7:0] OFS_XHDR  = 8'h1C;
  // Control fields
  localparam int CTRL_EMODE = 0;
  localparam int CTRL_OPTIN = 1;
  localparam int CTRL_STF   = 2;
  localparam int CTRL_MISC  = 8;
  localparam int MISC_W     = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_MSK = 32'h0000_FF07;
  // Exit information fields
  localparam int XI_VEC  = 0;
  localparam int XI_KIND = 8;
  localparam int XI_VAL  = 31;
  localparam logic [2:0] KIND_BRK = 3'h6;
  localparam logic [2:0] KIND_EXC = 3'h3;
  localparam logic [31:0] RESUME_LEAF = 32'h0000_0003;
  // Exception vectors
  localparam logic [7:0] VEC_DIV   = 8'h00;
  localparam logic [7:0] VEC_DBG   = 8'h01;
  localparam logic [7:0] VEC_BRK   = 8'h03;
  localparam logic [7:0] VEC_BND   = 8'h05;
  localparam logic [7:0] VEC_UD    = 8'h06;
  localparam logic [7:0] VEC_GP    = 8'h0D;
  localparam logic [7:0] VEC_PF    = 8'h0E;
  localparam logic [7:0] VEC_MATH  = 8'h10;
  localparam logic [7:0] VEC_ALIGN = 8'h11;
  localparam logic [7:0] VEC_SIMD  = 8'h13;
  // Extended features that take their init state (bits 62:2, low word)
  localparam logic [31:0] XINIT_MSK = 32'hFFFF_FFFC;
  // Sequencer states, Gray along the path
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_SAVE  = 3'h1,
    ST_XHDR  = 3'h3,
    ST_INFO  = 3'h2,
    ST_SYNTH = 3'h6,
    ST_FRAME = 3'h7,
    ST_EXIT  = 3'h5,
    ST_TAIL  = 3'h4
  } axs_st_t;
  // Event handed over by the delivery logic
  typedef struct packed {
    logic [7:0] vector;
    logic       keep_rf;
    logic       rep_mid;
    logic       arch_rf;
    logic       efer_lma;
    logic       cs_l;
    logic       vmx_mon_trap;
    logic       osxsave;
  } axs_evt_t;
  // Synthetic register values
  typedef struct packed {
    logic [31:0] rip;
    logic [31:0] rax;
    logic [31:0] rbx;
    logic [31:0] rcx;
  } axs_syn_t;
  // Fault details for the misc region
  typedef struct packed {
    logic [31:0] fault_addr;
    logic [31:0] err_code;
    logic [31:0] rsvd;
  } axs_misc_t;
endpackage

// ---- axs_dlv.sv ----
// Model of the event delivery logic beside the exit sequencer.
// Assumes the bench pulses fire for one cycle with cfg set up.
`timescale 1ns/10ps
`default_nettype none
module axs_dlv (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              fire,
  input  wire axs_pkg::axs_evt_t cfg,
  input  wire logic              busy,
  output logic                   evt_req,
  output axs_pkg::axs_evt_t      evt
);
  // One cycle offer while idle; the event lines scramble when not offered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_req <= 1'b0;
      evt     <= '0;
    end else if (fire && !busy) begin
      evt_req <= 1'b1;
      evt     <= cfg;
    end else begin
      evt_req <= 1'b0;
      evt     <= ~evt;
    end
  end
endmodule // axs_dlv
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench: sequencer, register bus and delivery model.
// Assumes zero-wait slave; a global cycle limit cuts a hang short.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [31:0] FEAT = 32'h0000_03E7;
  localparam logic [31:0] EPTR = 32'h4000_1230;
  localparam logic [31:0] TLA  = 32'h7000_0040;
  localparam logic [31:0] HBV  = 32'h5A5A_F00F;
  logic        pclk, presetn, psel, penable, pwrite, fire, evt_req;
  logic        pready, pslverr, busy, gpr_save, save_wide64, fx_fmt64, ssa_tf, ssa_rf;
  logic        fsgs_base_save, hdr_clear, info_wr, misc_wr, synth_load, stack_reload;
  logic        fsgs_restore, live_rf_clear, xcr0_restore, tlb_flush, bp_outside_resume;
  logic        dbg_restore, live_tf, perf_resume, mon_trap_pend, cr2_low_clear, done;
  logic [7:0]  paddr, misc_save_mask;
  logic [31:0] pwdata, prdata, hdr_bv_in, fault_addr_in, err_code_in;
  logic [31:0] xsave_en_mask, hdr_bv_out, xinit_mask;
  axs_pkg::axs_evt_t  evt, cfg;
  axs_pkg::axs_misc_t misc_out;
  axs_pkg::axs_syn_t  syn;
  int          mismatches, comparisons, cycles;

  axs_seq DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .evt_req, .evt, .hdr_bv_in, .fault_addr_in, .err_code_in, .busy,
    .gpr_save, .save_wide64, .fx_fmt64, .xsave_en_mask, .misc_save_mask, .fsgs_base_save,
    .ssa_tf, .ssa_rf, .hdr_clear, .hdr_bv_out, .info_wr, .misc_wr, .misc_out, .synth_load,
    .syn, .xinit_mask, .stack_reload, .fsgs_restore, .live_rf_clear, .xcr0_restore,
    .tlb_flush, .bp_outside_resume, .dbg_restore, .live_tf, .perf_resume, .mon_trap_pend,
    .cr2_low_clear, .done);
  axs_dlv PEER (.pclk, .presetn, .fire, .cfg, .busy, .evt_req, .evt);

  ////////////////////////////////////////////////////////////////
  // Clock, and a cycle limit well above the whole run
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    if (mismatches == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  // One transfer; idle cycle after it so psel never toggles twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////
  // One exit: setup, fire, collect pulses, then judge frame and registers
  task automatic ev(input logic [7:0] v, input logic [6:0] b, input logic [31:0] c,
                    input logic [31:0] xi);
    logic [31:0] q, f0, xm, xim;
    logic        e, mw;
    logic [15:0] fl;
    logic [12:0] g;
    axs_pkg::axs_syn_t sy;
    int n;
    mw = (v == axs_pkg::VEC_PF || v == axs_pkg::VEC_GP) && c[8];
    apb(1'b1, axs_pkg::OFS_CTRL, c | 32'h1, q, e);
    apb(1'b0, axs_pkg::OFS_FIDX, 32'h0, f0, e);
    hdr_bv_in <= HBV;
    fault_addr_in <= {24'hC0DE12, v};
    err_code_in <= {24'h0, ~v};
    cfg <= {v, b};
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    {n, fl, g, xm, xim, sy} = '0;
    do begin
      @(posedge pclk);
      n++;
      if (gpr_save === 1'b1) begin
        g = {busy, save_wide64, fx_fmt64, ssa_tf, ssa_rf, misc_save_mask};
        xm = xsave_en_mask;
      end
      if (synth_load === 1'b1) begin
        sy = syn;
        xim = xinit_mask;
      end
      fl = fl | {gpr_save, synth_load, fsgs_base_save, hdr_clear, info_wr, stack_reload,
        fsgs_restore, live_rf_clear, bp_outside_resume, tlb_flush, xcr0_restore,
        dbg_restore, perf_resume, mon_trap_pend, cr2_low_clear, misc_wr};
    end while (done !== 1'b1 && n < 20);
    chk(32'(n), 32'h8);
    chk(32'(g), {19'h0, 1'b1, b[3] & b[2], b[3] & b[2], 1'b0, b[5] | !b[6] | b[4], c[15:8]});
    chk(xm, FEAT);
    chk(xim, FEAT & axs_pkg::XINIT_MSK);
    chk(hdr_bv_out, HBV & FEAT);
    chk(sy.rip, EPTR);
    chk(sy.rcx, EPTR);
    chk(sy.rax, axs_pkg::RESUME_LEAF);
    chk(sy.rbx, TLA);
    chk(32'(fl), {16'h0, 10'h3FF, b[0], !c[1], !c[1], b[1], v == axs_pkg::VEC_PF, mw});
    if (!c[1]) chk(32'(live_tf), 32'(c[2]));
    if (mw) chk(misc_out.fault_addr, v == axs_pkg::VEC_PF ? {24'hC0DE12, v} : 32'h0);
    if (mw) chk(misc_out.err_code, {24'h0, ~v});
    if (mw) chk(misc_out.rsvd, 32'h0);
    apb(1'b0, axs_pkg::OFS_XINFO, 32'h0, q, e);
    chk(q, xi);
    apb(1'b0, axs_pkg::OFS_FIDX, 32'h0, q, e);
    chk(q, f0 + 32'h1);
    apb(1'b0, axs_pkg::OFS_XHDR, 32'h0, q, e);
    chk(q, HBV & FEAT);
    apb(1'b0, axs_pkg::OFS_CTRL, 32'h0, q, e);
    chk(q, c & axs_pkg::CTRL_MSK & 32'hFFFF_FFFE);
  endtask

  // Reset value, read-only and unmapped places, then setup values
  task automatic t_regs;
    logic [31:0] q;
    logic        e;
    apb(1'b0, axs_pkg::OFS_CTRL, 32'h0, q, e);
    chk(q, axs_pkg::CTRL_RST);
    apb(1'b1, axs_pkg::OFS_XINFO, 32'hFFFF_FFFF, q, e);
    apb(1'b0, axs_pkg::OFS_XINFO, 32'h0, q, e);
    chk(q, 32'h0);
    apb(1'b0, axs_pkg::OFS_STAT, 32'h0, q, e);
    chk(q, 32'h0);
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
    apb(1'b1, axs_pkg::OFS_FEAT, FEAT, q, e);
    apb(1'b1, axs_pkg::OFS_EPTR, EPTR, q, e);
    apb(1'b1, axs_pkg::OFS_TLA, TLA, q, e);
  endtask

  // Every listed exception, modes and flags varied along the loop
  task automatic t_exc;
    logic [7:0] vt [8];
    vt = '{axs_pkg::VEC_DIV, axs_pkg::VEC_DBG, axs_pkg::VEC_BRK, axs_pkg::VEC_BND,
      axs_pkg::VEC_UD, axs_pkg::VEC_MATH, axs_pkg::VEC_ALIGN, axs_pkg::VEC_SIMD};
    for (int i = 0; i < 8; i++) begin
      ev(vt[i], {i[0], 2'b01, i[1], i[1] | i[2], i[2], i[0]}, {16'h0, 8'h03, 5'h0, i[2], 2'b0},
        {1'b1, 20'h0, (vt[i] == axs_pkg::VEC_BRK) ? 3'h6 : 3'h3, vt[i]});
    end
  endtask

  // Faults with and without details, opt-in, and a plain interrupt
  task automatic t_fault;
    ev(axs_pkg::VEC_PF, 7'b1100111, 32'h0000_0104, 32'h8000_030E);
    ev(axs_pkg::VEC_GP, 7'b0000000, 32'h0000_0302, 32'h8000_030D);
    ev(axs_pkg::VEC_PF, 7'b0001000, 32'h0000_0200, 32'h0);
    ev(8'h20, 7'b1000001, 32'h0000_0000, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, fire, mismatches, comparisons, cycles} = '0;
    {paddr, pwdata, hdr_bv_in, fault_addr_in, err_code_in, cfg} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_exc();
    t_fault();
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
